// >>> design/status_page_pkg.sv
// package of constants for the status page monitor
package status_page_pkg;
   // ****************************************
   // page numbers
   // ****************************************
   localparam logic [3:0] PAGE_FLAGS     = 4'h0;
   localparam logic [3:0] PAGE_SECTOR    = 4'h1;
   localparam logic [3:0] PAGE_BUSCTL    = 4'h2;
   localparam logic [3:0] PAGE_DEPTH     = 4'h3;
   localparam logic [3:0] PAGE_PATTERN   = 4'h4;
   localparam logic [3:0] PAGE_ALT_A     = 4'h5;
   localparam logic [3:0] PAGE_ALT_B     = 4'h6;
   localparam logic [3:0] PAGE_CONTROL   = 4'h7;
   localparam logic [3:0] PAGE_TIMING    = 4'h8;
   localparam logic [7:0] ALT_A_VALUE    = 8'h55;
   localparam logic [7:0] ALT_B_VALUE    = 8'haa;
   // ****************************************
   // page register fields
   // ****************************************
   localparam int PAGE_SEL_MSB  = 3;
   localparam int HIST_CLR_BIT  = 4;
   // ****************************************
   // reset values of backplane parameters
   // ****************************************
   localparam logic [7:0] SECTOR_RESET   = 8'h00;
   localparam logic [7:0] BUSCTL_RESET   = 8'h00;
   localparam logic [7:0] DEPTH_RESET    = 8'h24;
   localparam logic [7:0] PAGE_RESET     = 8'h00;
   // ****************************************
   // status word layout
   // ****************************************
   localparam int WORD_TYPE_LSB  = 12;
   localparam int WORD_CLK_LSB   = 10;
   localparam int WORD_RDY_BIT   = 9;
   localparam int WORD_REG_BIT   = 8;
   // board type code, value arbitrary
   localparam logic [3:0] BOARD_TYPE_DEFAULT = 4'h5;
   // ****************************************
   // backplane register indices
   // ****************************************
   localparam logic [3:0] IDX_PAGE       = 4'h5;
   localparam logic [3:0] IDX_DEPTH      = 4'h6;
   localparam logic [3:0] IDX_SECTOR     = 4'h7;
   localparam logic [3:0] IDX_BUSCTL     = 4'h8;
   // ****************************************
   // device numbers
   // ****************************************
   localparam logic DEV_TOP = 1'b0;
   localparam logic DEV_BOT = 1'b1;
endpackage

// >>> design/sync_bit.sv
// two-stage synchroniser for a bundle of levels
`timescale 1ns/1ns
`default_nettype none
module sync_bit #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   // level in and out
   input  wire logic [WIDTH-1:0] asyncIn,
   output var  logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         meta_q  <= '0;
         syncOut <= '0;
      end else begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule
`default_nettype wire

// >>> design/board_pages.sv
// status pages and history flags of one daughterboard
`timescale 1ns/1ns
`default_nettype none
module board_pages (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // control
   input  wire logic       clearHist,
   input  wire logic [3:0] pageSel,
   // parameter echoes
   input  wire logic [7:0] homeSector,
   input  wire logic [7:0] busControl,
   input  wire logic [7:0] pipeDepth,
   // events, already synchronised
   input  wire logic       frameworkLock,
   input  wire logic       alignError,
   input  wire logic       trackFound,
   input  wire logic       levelOneAcceptSeen,
   input  wire logic       trackerResetSeen,
   input  wire logic       syncGapSeen,
   input  wire logic       firstCrossingSeen,
   input  wire logic       gapLengthError,
   input  wire logic       crossingTimingError,
   input  wire logic [5:0] patternFault,
   // selected page
   output var  logic [7:0] pageByte
);
   // sticky flags: align, track, 4 observations, 2 timing, 6 pattern
   localparam int NHIST = 14;
   logic [NHIST-1:0] ev;
   logic [NHIST-1:0] hist_q;

   assign ev = {patternFault, gapLengthError, crossingTimingError,
                levelOneAcceptSeen, trackerResetSeen, syncGapSeen,
                firstCrossingSeen, trackFound, alignError};

   // set wins over clear so a coinciding event survives
   always_ff @(posedge ref_clk) begin
      if (!rst_b)
         hist_q <= '0;
      else
         hist_q <= (clearHist ? '0 : hist_q) | ev;
   end

   always_comb begin
      case (pageSel)
         status_page_pkg::PAGE_FLAGS:   pageByte = {5'h00, hist_q[1], hist_q[0],
                                                    frameworkLock};
         status_page_pkg::PAGE_SECTOR:  pageByte = homeSector;
         status_page_pkg::PAGE_BUSCTL:  pageByte = busControl;
         status_page_pkg::PAGE_DEPTH:   pageByte = pipeDepth;
         status_page_pkg::PAGE_PATTERN: pageByte = {2'b00, hist_q[13:8]};
         status_page_pkg::PAGE_ALT_A:   pageByte = status_page_pkg::ALT_A_VALUE;
         status_page_pkg::PAGE_ALT_B:   pageByte = status_page_pkg::ALT_B_VALUE;
         status_page_pkg::PAGE_CONTROL: pageByte = {4'h0, hist_q[5:2]};
         status_page_pkg::PAGE_TIMING:  pageByte = {6'h00, hist_q[7:6]};
         default:                       pageByte = 8'h00;
      endcase
   end

   chk_clear_zeroes: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clearHist && ev == '0 |=> hist_q == '0)
      else $error("history not cleared");
   chk_sticky_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !clearHist |=> (hist_q & $past(hist_q)) == $past(hist_q))
      else $error("history flag dropped");
   chk_event_kept: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ev[0] |=> hist_q[0])
      else $error("event lost");
endmodule
`default_nettype wire

// >>> design/status_page_monitor.sv
// top of the status page monitor: backplane writes, pages, status word
// ****************************************
// How it works
// - nine pages each board, one shown
// - pages one-three echo backplane parameters
// - lock flag follows counter lock
// - alignment error after sync procedure
// - track found flag on valid track
// - four control-bit observation flags
// - gap length error flag
// - crossing timing error flag
// - page four holds pattern errors
// - motherboard inputs map to local links
// - links two, four at bits one, three
// - history flags stay set until cleared
// - page register bit four clears history
// - clear acts on current device only
// - status word sent continuously
// - fixed status word bit layout
// - ready needs both boards initialised
// - regulator bit low on either fault
// - low byte is selected page
// - device zero top, one bottom
// ****************************************
`timescale 1ns/1ns
`default_nettype none
module status_page_monitor #(
   parameter logic [3:0] BOARD_TYPE = status_page_pkg::BOARD_TYPE_DEFAULT
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   // backplane register write, same clock domain
   input  wire logic        regWrite,
   input  wire logic [3:0]  regIndex,
   input  wire logic [7:0]  regData,
   input  wire logic        currentDevice,
   // motherboard status pins
   input  wire logic [1:0]  clockSelect,
   input  wire logic        topReady,
   input  wire logic        botReady,
   input  wire logic        topRegFault,
   input  wire logic        botRegFault,
   // top board events
   input  wire logic        topLock,
   input  wire logic        topAlign,
   input  wire logic        topTrack,
   input  wire logic        topAccept,
   input  wire logic        topTrkReset,
   input  wire logic        topSyncGap,
   input  wire logic        topFirstX,
   input  wire logic        topGapErr,
   input  wire logic        topXingErr,
   // bottom board events
   input  wire logic        botLock,
   input  wire logic        botAlign,
   input  wire logic        botTrack,
   input  wire logic        botAccept,
   input  wire logic        botTrkReset,
   input  wire logic        botSyncGap,
   input  wire logic        botFirstX,
   input  wire logic        botGapErr,
   input  wire logic        botXingErr,
   // test pattern faults per motherboard input 0..9
   input  wire logic [9:0]  inputPatternFault,
   // slow monitor status word
   output var  logic [15:0] statusWord_q
);
   // ****************************************
   // synchronise pin levels
   // ****************************************
   localparam int NPIN = 34;
   logic [NPIN-1:0] pinsRaw;
   logic [NPIN-1:0] pins;

   assign pinsRaw = {clockSelect, topReady, botReady, topRegFault, botRegFault,
                     topLock, topAlign, topTrack, topAccept, topTrkReset,
                     topSyncGap, topFirstX, topGapErr, topXingErr,
                     botLock, botAlign, botTrack, botAccept, botTrkReset,
                     botSyncGap, botFirstX, botGapErr, botXingErr,
                     inputPatternFault};

   sync_bit #(.WIDTH(NPIN)) u_sync (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .asyncIn (pinsRaw),
      .syncOut (pins)
   );

   logic [1:0] sClk;
   logic       sTopRdy;
   logic       sBotRdy;
   logic       sTopFlt;
   logic       sBotFlt;
   logic [8:0] sTopEv;
   logic [8:0] sBotEv;
   logic [9:0] sPatt;

   assign sClk    = pins[33:32];
   assign sTopRdy = pins[31];
   assign sBotRdy = pins[30];
   assign sTopFlt = pins[29];
   assign sBotFlt = pins[28];
   assign sTopEv  = pins[27:19];
   assign sBotEv  = pins[18:10];
   assign sPatt   = pins[9:0];

   // ****************************************
   // link renumbering
   // ****************************************
   // local order {6,5,4,3,2,0}; bottom takes inputs 7 and 9 as links 0, 2
   logic [5:0] topPatt;
   logic [5:0] botPatt;

   assign topPatt = {sPatt[6:3], sPatt[2], sPatt[0]};
   assign botPatt = {sPatt[6:3], sPatt[9], sPatt[7]};

   // ****************************************
   // per-device backplane parameters
   // ****************************************
   logic [7:0] page_q    [2];
   logic [7:0] sector_q  [2];
   logic [7:0] busctl_q  [2];
   logic [7:0] depth_q   [2];
   logic [1:0] clear;
   logic       devSel;

   assign devSel = currentDevice;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_dev
         always_ff @(posedge ref_clk) begin
            if (!rst_b) begin
               page_q[g]   <= status_page_pkg::PAGE_RESET;
               sector_q[g] <= status_page_pkg::SECTOR_RESET;
               busctl_q[g] <= status_page_pkg::BUSCTL_RESET;
               depth_q[g]  <= status_page_pkg::DEPTH_RESET;
            end else if (regWrite && devSel == 1'(g)) begin
               case (regIndex)
                  status_page_pkg::IDX_PAGE:   page_q[g]   <= regData;
                  status_page_pkg::IDX_SECTOR: sector_q[g] <= regData;
                  status_page_pkg::IDX_BUSCTL: busctl_q[g] <= regData;
                  status_page_pkg::IDX_DEPTH:  depth_q[g]  <= regData;
                  default: ;
               endcase
            end
         end
         // level of the stored bit; clears as long as it stays written
         assign clear[g] = page_q[g][status_page_pkg::HIST_CLR_BIT];
      end
   endgenerate

   // ****************************************
   // the two boards
   // ****************************************
   logic [7:0] topByte;
   logic [7:0] botByte;

   board_pages u_top (
      .ref_clk             (ref_clk),
      .rst_b               (rst_b),
      .clearHist           (clear[0]),
      .pageSel             (page_q[0][status_page_pkg::PAGE_SEL_MSB:0]),
      .homeSector          (sector_q[0]),
      .busControl          (busctl_q[0]),
      .pipeDepth           (depth_q[0]),
      .frameworkLock       (sTopEv[8]),
      .alignError          (sTopEv[7]),
      .trackFound          (sTopEv[6]),
      .levelOneAcceptSeen  (sTopEv[5]),
      .trackerResetSeen    (sTopEv[4]),
      .syncGapSeen         (sTopEv[3]),
      .firstCrossingSeen   (sTopEv[2]),
      .gapLengthError      (sTopEv[1]),
      .crossingTimingError (sTopEv[0]),
      .patternFault        (topPatt),
      .pageByte            (topByte)
   );

   board_pages u_bot (
      .ref_clk             (ref_clk),
      .rst_b               (rst_b),
      .clearHist           (clear[1]),
      .pageSel             (page_q[1][status_page_pkg::PAGE_SEL_MSB:0]),
      .homeSector          (sector_q[1]),
      .busControl          (busctl_q[1]),
      .pipeDepth           (depth_q[1]),
      .frameworkLock       (sBotEv[8]),
      .alignError          (sBotEv[7]),
      .trackFound          (sBotEv[6]),
      .levelOneAcceptSeen  (sBotEv[5]),
      .trackerResetSeen    (sBotEv[4]),
      .syncGapSeen         (sBotEv[3]),
      .firstCrossingSeen   (sBotEv[2]),
      .gapLengthError      (sBotEv[1]),
      .crossingTimingError (sBotEv[0]),
      .patternFault        (botPatt),
      .pageByte            (botByte)
   );

   // ****************************************
   // status word
   // ****************************************
   logic [15:0] word_d;

   always_comb begin
      word_d = '0;
      word_d[15:status_page_pkg::WORD_TYPE_LSB] = BOARD_TYPE;
      word_d[11:status_page_pkg::WORD_CLK_LSB]  = sClk;
      word_d[status_page_pkg::WORD_RDY_BIT]     = sTopRdy & sBotRdy;
      word_d[status_page_pkg::WORD_REG_BIT]     = ~(sTopFlt | sBotFlt);
      word_d[7:0] = (devSel == status_page_pkg::DEV_BOT) ? botByte : topByte;
   end

   // refreshed every cycle; the serialiser samples it freely
   always_ff @(posedge ref_clk) begin
      if (!rst_b)
         statusWord_q <= '0;
      else
         statusWord_q <= word_d;
   end

   chk_ready_both: assert property (@(posedge ref_clk) disable iff (!rst_b)
      statusWord_q[status_page_pkg::WORD_RDY_BIT] |-> $past(sTopRdy) && $past(sBotRdy))
      else $error("ready without both boards");
   chk_reg_fault: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $past(sTopFlt) || $past(sBotFlt) |-> !statusWord_q[status_page_pkg::WORD_REG_BIT])
      else $error("regulator good during fault");
   chk_type_code: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $past(rst_b) |-> statusWord_q[15:12] == BOARD_TYPE)
      else $error("board type wrong");
   chk_depth_echo: assert property (@(posedge ref_clk) disable iff (!rst_b)
      regWrite && regIndex == status_page_pkg::IDX_DEPTH && !devSel
      |=> depth_q[0] == $past(regData))
      else $error("depth not stored");
   chk_empty_pages: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $past(rst_b) && $past(page_q[devSel][3:0]) > 4'h8 && $past(devSel) == devSel
      |-> statusWord_q[7:0] == 8'h00)
      else $error("unassigned page not zero");
   chk_clear_other: assert property (@(posedge ref_clk) disable iff (!rst_b)
      regWrite && !devSel |=> page_q[1] == $past(page_q[1]))
      else $error("other device touched");

   // ****************************************
   // backplane register checks
   // ****************************************
   // the four indices that steer a daughterboard parameter; all else is dropped
   function automatic logic known_index(input logic [3:0] idx);
      return idx == status_page_pkg::IDX_PAGE || idx == status_page_pkg::IDX_DEPTH ||
             idx == status_page_pkg::IDX_SECTOR || idx == status_page_pkg::IDX_BUSCTL;
   endfunction

   chk_depth_bot: assert property (@(posedge ref_clk) disable iff (!rst_b)
      regWrite && regIndex == status_page_pkg::IDX_DEPTH && devSel
      |=> depth_q[1] == $past(regData))
      else $error("bottom depth not stored");
   chk_sector_top: assert property (@(posedge ref_clk) disable iff (!rst_b)
      regWrite && regIndex == status_page_pkg::IDX_SECTOR && !devSel
      |=> sector_q[0] == $past(regData))
      else $error("top sector not stored");
   chk_sector_bot: assert property (@(posedge ref_clk) disable iff (!rst_b)
      regWrite && regIndex == status_page_pkg::IDX_SECTOR && devSel
      |=> sector_q[1] == $past(regData))
      else $error("bottom sector not stored");
   chk_busctl_top: assert property (@(posedge ref_clk) disable iff (!rst_b)
      regWrite && regIndex == status_page_pkg::IDX_BUSCTL && !devSel
      |=> busctl_q[0] == $past(regData))
      else $error("top bus control not stored");
   chk_busctl_bot: assert property (@(posedge ref_clk) disable iff (!rst_b)
      regWrite && regIndex == status_page_pkg::IDX_BUSCTL && devSel
      |=> busctl_q[1] == $past(regData))
      else $error("bottom bus control not stored");
   chk_page_top: assert property (@(posedge ref_clk) disable iff (!rst_b)
      regWrite && regIndex == status_page_pkg::IDX_PAGE && !devSel
      |=> page_q[0] == $past(regData))
      else $error("top page not stored");
   chk_page_bot: assert property (@(posedge ref_clk) disable iff (!rst_b)
      regWrite && regIndex == status_page_pkg::IDX_PAGE && devSel
      |=> page_q[1] == $past(regData))
      else $error("bottom page not stored");
   chk_top_untouched: assert property (@(posedge ref_clk) disable iff (!rst_b)
      regWrite && devSel |=> page_q[0] == $past(page_q[0]))
      else $error("top touched by bottom write");
   chk_index_top: assert property (@(posedge ref_clk) disable iff (!rst_b)
      regWrite && !known_index(regIndex)
      |=> page_q[0] == $past(page_q[0]) && depth_q[0] == $past(depth_q[0])
          && sector_q[0] == $past(sector_q[0]) && busctl_q[0] == $past(busctl_q[0]))
      else $error("unknown index changed a top register");
   chk_index_bot: assert property (@(posedge ref_clk) disable iff (!rst_b)
      regWrite && !known_index(regIndex)
      |=> page_q[1] == $past(page_q[1]) && depth_q[1] == $past(depth_q[1])
          && sector_q[1] == $past(sector_q[1]) && busctl_q[1] == $past(busctl_q[1]))
      else $error("unknown index changed a bottom register");

   // ****************************************
   // status word checks
   // ****************************************
   chk_reset_word: assert property (@(posedge ref_clk)
      !rst_b |=> statusWord_q == 16'h0000)
      else $error("status word not cleared by reset");
   chk_depth_reset: assert property (@(posedge ref_clk)
      !rst_b |=> depth_q[0] == status_page_pkg::DEPTH_RESET
                 && depth_q[1] == status_page_pkg::DEPTH_RESET)
      else $error("depth reset value wrong");
   chk_ready_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $past(rst_b) && $past(sTopRdy) && $past(sBotRdy)
      |-> statusWord_q[status_page_pkg::WORD_RDY_BIT])
      else $error("ready missing with both boards up");
   chk_reg_good: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $past(rst_b) && !$past(sTopFlt) && !$past(sBotFlt)
      |-> statusWord_q[status_page_pkg::WORD_REG_BIT])
      else $error("regulator bit low without fault");
   chk_clock_field: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $past(rst_b) |-> statusWord_q[11:10] == $past(sClk))
      else $error("clock select field wrong");
   chk_top_byte: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $past(rst_b) && $past(devSel) == status_page_pkg::DEV_TOP
      |-> statusWord_q[7:0] == $past(topByte))
      else $error("top page byte not shown");
   chk_bot_byte: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $past(rst_b) && $past(devSel) == status_page_pkg::DEV_BOT
      |-> statusWord_q[7:0] == $past(botByte))
      else $error("bottom page byte not shown");
   chk_alt_top: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $past(rst_b) && $past(page_q[0][3:0]) == status_page_pkg::PAGE_ALT_A && !$past(devSel)
      |-> statusWord_q[7:0] == status_page_pkg::ALT_A_VALUE)
      else $error("page five pattern wrong");
   chk_alt_bot: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $past(rst_b) && $past(page_q[1][3:0]) == status_page_pkg::PAGE_ALT_B && $past(devSel)
      |-> statusWord_q[7:0] == status_page_pkg::ALT_B_VALUE)
      else $error("page six pattern wrong");

   // ****************************************
   // clear and link checks
   // ****************************************
   chk_clear_top: assert property (@(posedge ref_clk) disable iff (!rst_b)
      regWrite && regIndex == status_page_pkg::IDX_PAGE && !devSel
      |=> clear[0] == $past(regData[status_page_pkg::HIST_CLR_BIT]))
      else $error("top clear level wrong");
   chk_clear_bot: assert property (@(posedge ref_clk) disable iff (!rst_b)
      regWrite && regIndex == status_page_pkg::IDX_PAGE && devSel
      |=> clear[1] == $past(regData[status_page_pkg::HIST_CLR_BIT]))
      else $error("bottom clear level wrong");
   chk_shared_links: assert property (@(posedge ref_clk) disable iff (!rst_b)
      topPatt[5:2] == botPatt[5:2])
      else $error("shared links differ between boards");
endmodule
`default_nettype wire

// >>> verif/crate_ctrl_model.sv
// crate controller model: backplane writes to the current device
`timescale 1ns/1ns
`default_nettype none
module crate_ctrl_model (
   // clock
   input  wire logic       ref_clk,
   // backplane write
   output var  logic       regWrite,
   output var  logic [3:0] regIndex,
   output var  logic [7:0] regData,
   output var  logic       currentDevice
);
   initial begin
      regWrite = 1'b0;
      regIndex = 4'hf;
      regData = 8'h00;
      currentDevice = 1'b0;
   end
   // ****************************************
   // write cycle
   // ****************************************
   // a spare cycle after each write so the strobe never toggles in one step
   task automatic wr(input logic dev, input logic [3:0] idx, input logic [7:0] d);
      currentDevice = dev;
      regIndex = idx;
      regData = d;
      regWrite = 1'b1;
      @(posedge ref_clk);
      #1;
      regWrite = 1'b0;
      regIndex = ~idx;
      regData = ~d;
      @(posedge ref_clk);
      #1;
   endtask
   // zero, clear, zero leaves the clear bit low afterwards
   task automatic clr(input logic dev);
      wr(dev, status_page_pkg::IDX_PAGE, 8'h00);
      wr(dev, status_page_pkg::IDX_PAGE, 8'h10);
      wr(dev, status_page_pkg::IDX_PAGE, 8'h00);
   endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench of the status page monitor
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic        ref_clk;
   logic        rst_b;
   logic        regWrite;
   logic [3:0]  regIndex;
   logic [7:0]  regData;
   logic        currentDevice;
   logic [1:0]  clockSelect;
   logic [3:0]  pins;
   logic [8:0]  et;
   logic [8:0]  eb;
   logic [8:0]  st;
   logic [8:0]  sb;
   logic [9:0]  pf;
   logic [9:0]  pfs;
   logic [15:0] statusWord_q;
   logic [31:0] rnd;
   logic [7:0]  prm [2][3];
   int          errors;
   int          tests_run;

   crate_ctrl_model m (.ref_clk(ref_clk), .regWrite(regWrite), .regIndex(regIndex),
      .regData(regData), .currentDevice(currentDevice));
   status_page_monitor u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .regWrite(regWrite),
      .regIndex(regIndex), .regData(regData), .currentDevice(currentDevice),
      .clockSelect(clockSelect), .topReady(pins[3]), .botReady(pins[2]),
      .topRegFault(pins[1]), .botRegFault(pins[0]),
      .topLock(et[0]), .topAlign(et[1]), .topTrack(et[2]), .topAccept(et[3]),
      .topTrkReset(et[4]), .topSyncGap(et[5]), .topFirstX(et[6]),
      .topGapErr(et[7]), .topXingErr(et[8]),
      .botLock(eb[0]), .botAlign(eb[1]), .botTrack(eb[2]), .botAccept(eb[3]),
      .botTrkReset(eb[4]), .botSyncGap(eb[5]), .botFirstX(eb[6]),
      .botGapErr(eb[7]), .botXingErr(eb[8]),
      .inputPatternFault(pf), .statusWord_q(statusWord_q));

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] exp_word(input logic [7:0] pg);
      return {status_page_pkg::BOARD_TYPE_DEFAULT, clockSelect, pins[3] & pins[2],
              ~(pins[1] | pins[0]), pg};
   endfunction
   function automatic logic [7:0] exp_links(input logic dev, input logic [9:0] f);
      return dev ? {2'b00, f[6:3], f[9], f[7]} : {2'b00, f[6:3], f[2], f[0]};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      tests_run++;
      if (seen !== want) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // unused page bits 7:5 get random junk; only the low nibble selects
   task automatic look(input logic dev, input logic [3:0] pg, input logic [7:0] want);
      rnd = lfsr(rnd);
      m.wr(dev, status_page_pkg::IDX_PAGE, {rnd[2:0], 1'b0, pg});
      check(statusWord_q, exp_word(want));
   endtask
   task automatic end_sim;
      if (errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rst_b = 1'b0;
      clockSelect = 2'h0;
      pins = 4'h0;
      et = 9'h000;
      eb = 9'h000;
      pf = 10'h000;
      rnd = 32'hab357d72;
      errors = 0;
      tests_run = 0;
      tick(16);
      check(statusWord_q, 16'h0000);
      rst_b = 1'b1;
      for (int d = 0; d < 2; d++) begin
         look(d[0], 4'h3, status_page_pkg::DEPTH_RESET);
         look(d[0], 4'h1, status_page_pkg::SECTOR_RESET);
         for (int p = 5; p < 16; p++)
            if (p != 7 && p != 8)
               look(d[0], p[3:0], p == 5 ? 8'h55 : (p == 6 ? 8'haa : 8'h00));
      end
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         {clockSelect, pins} = rnd[5:0];
         for (int d = 0; d < 2; d++) begin
            m.clr(d[0]);
            for (int k = 0; k < 3; k++) begin
               rnd = lfsr(rnd);
               prm[d][k] = (i == 0) ? 8'hff : rnd[7:0];
               // depth, sector, bus control in index order
               m.wr(d[0], 4'h6 + k[3:0], prm[d][k]);
            end
            m.wr(d[0], 4'h9, rnd[15:8]);
            m.wr(d[0], 4'h0, rnd[23:16]);
         end
         rnd = lfsr(rnd);
         st = (i == 0) ? 9'h1ff : rnd[8:0];
         sb = rnd[17:9];
         pfs = (i == 0) ? 10'h3ff : rnd[27:18];
         et = st;
         eb = sb;
         pf = pfs;
         tick(2);
         et = {8'h00, st[0]};
         eb = {8'h00, sb[0]};
         pf = 10'h000;
         tick(4);
         for (int d = 0; d < 2; d++) begin
            logic [8:0] e;
            e = d ? sb : st;
            look(d[0], 4'h0, {5'h00, e[2], e[1], e[0]});
            look(d[0], 4'h7, {4'h0, e[3], e[4], e[5], e[6]});
            look(d[0], 4'h8, {6'h00, e[7], e[8]});
            look(d[0], 4'h4, exp_links(d[0], pfs));
            look(d[0], 4'h1, prm[d][1]);
            look(d[0], 4'h2, prm[d][2]);
            look(d[0], 4'h3, prm[d][0]);
         end
         // align held through the clear must survive it
         et[1] = 1'b1;
         tick(4);
         m.clr(1'b0);
         et[1] = 1'b0;
         tick(4);
         look(1'b0, 4'h0, {5'h00, 1'b0, 1'b1, st[0]});
         look(1'b0, 4'h7, 8'h00);
         look(1'b0, 4'h4, 8'h00);
         look(1'b1, 4'h7, {4'h0, sb[3], sb[4], sb[5], sb[6]});
      end
      end_sim();
   end
endmodule
`default_nettype wire
